// ---- verilog/strap_decoder_pkg.sv ----
// Constants, register map and state type for the node identifier strap decoder
package strap_decoder_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_SETUP_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_AXIS_SETUP_BASE = 8'h10;
	localparam logic [7:0] OFS_ALIAS_BASE = 8'h20;
	localparam logic [7:0] OFS_AXIS_STRIDE = 8'h04;
	// Setup control field positions
	localparam int CTRL_HW_SEL_BIT = 0;
	localparam int CTRL_VALID_BIT = 1;
	localparam int CTRL_ALIAS_MODE_BIT = 2;
	localparam int CTRL_COMMIT_BIT = 31;
	// Status field positions
	localparam int STAT_SAMPLED_BIT = 0;
	localparam int STAT_LOCKED_BIT = 1;
	localparam int STAT_BANK_LSB = 4;
	localparam int STAT_MSB_SW_BIT = 8;
	localparam int STAT_VENDOR_BIT = 9;
	localparam int STAT_LSS_LSB = 16;
	// Values after reset and fixed codes
	localparam logic [7:0] NODE_ID_DEFAULT = 8'hFF;
	localparam logic [7:0] NODE_ID_NONE = 8'h00;
	localparam logic [15:0] ALIAS_NONE = 16'h0000;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
	// Switch settle time before the one-shot sample
	localparam int CLK_PERIOD_PS = 25000;
	localparam int SETTLE_TIME_NS = 1000;
	localparam int SETTLE_CYCLES_RAW = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETTLE_CYCLES = (SETTLE_CYCLES_RAW < 1) ? 1 : SETTLE_CYCLES_RAW;
	localparam int SETTLE_CNT_W = 8;
	// Configuration sequence, once per power cycle
	typedef enum logic [2:0] {
		ST_SAMPLE = 3'b001,
		ST_WAIT_SETUP = 3'b010,
		ST_LOCKED = 3'b100
	} cfg_state_t;
endpackage

// ---- verilog/node_id_strap_decoder.sv ----
// Power-up strap sampler and per-axis node identifier decoder with Avalon-MM registers
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module node_id_strap_decoder #(
	parameter int NUM_AXES = 4, // Axes in the system, 1 to 7
	parameter bit ETHERCAT_VARIANT = 1'b0 // 1: Ethernet variant, 0: CAN variant
) (
	input wire logic core_clk_in, // 40 MHz clock
	input wire logic sys_rst_in, // Power-up reset, sync, active high
	input wire logic [3:0] id_switch_bank_in, // Bit 3 is position 1
	input wire logic protocol_or_id_msb_switch_in, // Protocol or identifier top bit
	input wire logic [7:0] avs_address_in, // Byte address
	input wire logic avs_read_in, // Read request
	input wire logic avs_write_in, // Write request
	input wire logic [31:0] avs_writedata_in, // Write data
	input wire logic [3:0] avs_byteenable_in, // Write byte lanes
	output logic [31:0] avs_readdata_out, // Read data
	output logic avs_waitrequest_out, // Stall, high when idle
	output logic [8*NUM_AXES-1:0] node_identifier_out, // Per-axis identifier
	output logic [16*NUM_AXES-1:0] station_alias_out, // Per-axis station alias
	output logic vendor_can_protocol_out, // Vendor CAN protocol chosen
	output logic [NUM_AXES-1:0] lss_inactive_out, // Per-axis LSS inactive
	output logic config_locked_out // Identifiers final
);
	import strap_decoder_pkg::*;

	// Configuration state, switch synchronisers and latches
	cfg_state_t state_reg;
	cfg_state_t state_next;
	logic [3:0] bank_meta_reg;
	logic [3:0] bank_sync_reg;
	logic msb_meta_reg;
	logic msb_sync_reg;
	logic [3:0] bank_lat_reg;
	logic msb_lat_reg;
	logic [SETTLE_CNT_W-1:0] settle_cnt_reg;
	// Setup, identifier and bus registers
	logic [2:0] ctrl_reg;
	logic [8*NUM_AXES-1:0] setup_id_reg;
	logic [8*NUM_AXES-1:0] node_id_reg;
	logic [16*NUM_AXES-1:0] alias_reg;
	logic [NUM_AXES-1:0] lss_reg;
	logic vendor_reg;
	logic locked_reg;
	logic wait_reg;
	logic [31:0] rdata_reg;

	// Bus decode
	wire bus_req = avs_read_in | avs_write_in;
	wire wr_go = avs_write_in & ~wait_reg;
	wire ctrl_hit = (avs_address_in[7:2] == OFS_SETUP_CTRL[7:2]);
	wire stat_hit = (avs_address_in[7:2] == OFS_STATUS[7:2]);
	wire setup_open = (state_reg != ST_LOCKED);
	wire ctrl_wr = wr_go & ctrl_hit & avs_byteenable_in[0] & setup_open;
	wire commit_go = wr_go & ctrl_hit & avs_byteenable_in[3] & avs_writedata_in[CTRL_COMMIT_BIT]
		& (state_reg == ST_WAIT_SETUP);
	wire settle_done = (settle_cnt_reg == SETTLE_CNT_W'(SETTLE_CYCLES - 1));
	wire eth_msb = ETHERCAT_VARIANT & msb_lat_reg;
	wire [2:0] ctrl_eff = ctrl_wr ? avs_writedata_in[2:0] : ctrl_reg; // Commit sees bits of its own write
	wire hw_forced = ctrl_eff[CTRL_HW_SEL_BIT] | ~ctrl_eff[CTRL_VALID_BIT];
	wire canopen_sel = ~ETHERCAT_VARIANT & ~msb_sync_reg;

	// Status word
	wire [31:0] stat_word = (32'(lss_reg) << STAT_LSS_LSB)
		| (32'(vendor_reg) << STAT_VENDOR_BIT)
		| (32'(msb_lat_reg) << STAT_MSB_SW_BIT)
		| (32'(bank_lat_reg) << STAT_BANK_LSB)
		| (32'(locked_reg) << STAT_LOCKED_BIT)
		| (32'(state_reg != ST_SAMPLE) << STAT_SAMPLED_BIT);
	wire [31:0] ctrl_word = 32'(ctrl_reg);

	// Per-axis read words, hits and identifiers
	logic [31:0] axis_rd [NUM_AXES];
	logic [NUM_AXES-1:0] axis_hit;
	logic [7:0] sw_id [NUM_AXES];
	logic [7:0] chosen_id [NUM_AXES];

	// Per-axis identifier derivation and register decode
	genvar gi;
	generate
		for (gi = 0; gi < NUM_AXES; gi++) begin : g_axis
			// Per-axis register hits
			wire [7:0] sid = setup_id_reg[8*gi +: 8];
			wire su_hit = (avs_address_in[7:2] == 6'((OFS_AXIS_SETUP_BASE + 8'(gi) * OFS_AXIS_STRIDE) >> 2));
			wire al_hit = (avs_address_in[7:2] == 6'((OFS_ALIAS_BASE + 8'(gi) * OFS_AXIS_STRIDE) >> 2));
			wire use_hw = hw_forced | (sid == NODE_ID_NONE);
			assign sw_id[gi] = {eth_msb, bank_lat_reg, 3'(gi + 1)};
			assign chosen_id[gi] = use_hw ? sw_id[gi] : sid;
			assign axis_hit[gi] = su_hit | al_hit;
			assign axis_rd[gi] = su_hit
				? {16'h0000, node_id_reg[8*gi +: 8], sid}
				: (al_hit ? {16'h0000, alias_reg[16*gi +: 16]} : READ_ZERO);

			// Setup identifier write, only until locked
			always_ff @(posedge core_clk_in) begin
				if (sys_rst_in) begin
					setup_id_reg[8*gi +: 8] <= NODE_ID_NONE;
				end else if (wr_go & su_hit & avs_byteenable_in[0] & setup_open) begin
					setup_id_reg[8*gi +: 8] <= avs_writedata_in[7:0];
				end
			end

			// Identifier, alias and LSS state per axis
			always_ff @(posedge core_clk_in) begin
				if (sys_rst_in) begin
					node_id_reg[8*gi +: 8] <= NODE_ID_DEFAULT;
					alias_reg[16*gi +: 16] <= ALIAS_NONE;
					lss_reg[gi] <= 1'b0;
				end else if (commit_go) begin
					node_id_reg[8*gi +: 8] <= chosen_id[gi];
					alias_reg[16*gi +: 16] <= (ETHERCAT_VARIANT & ctrl_eff[CTRL_ALIAS_MODE_BIT]
						& (chosen_id[gi] != NODE_ID_DEFAULT)) ? {8'h00, chosen_id[gi]} : ALIAS_NONE;
					lss_reg[gi] <= ~ETHERCAT_VARIANT & ~vendor_reg & (chosen_id[gi] == NODE_ID_DEFAULT);
				end else if ((state_reg == ST_SAMPLE) & settle_done) begin
					lss_reg[gi] <= canopen_sel;
				end
			end

			// Checks on every axis
			AST_AXIS_SW_ID: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
				commit_go && use_hw |=> node_id_reg[8*gi +: 8]
				== {$past(eth_msb), $past(bank_lat_reg), 3'(gi + 1)}) else $error("axis switch identifier wrong");
			AST_AXIS_SOFT_ID: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
				commit_go && !use_hw
				|=> node_id_reg[8*gi +: 8] == $past(sid)) else $error("axis software identifier wrong");
			AST_AXIS_LSS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
				locked_reg && !ETHERCAT_VARIANT && !vendor_reg
				|-> lss_reg[gi] == (node_id_reg[8*gi +: 8] == NODE_ID_DEFAULT)) else $error("axis LSS state wrong");
			AST_AXIS_ALIAS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
				locked_reg && ETHERCAT_VARIANT && ctrl_reg[CTRL_ALIAS_MODE_BIT] && node_id_reg[8*gi +: 8] != NODE_ID_DEFAULT
				|-> alias_reg[16*gi +: 16] == {8'h00, node_id_reg[8*gi +: 8]}) else $error("axis alias mismatch");
			AST_AXIS_ALIAS_255: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
				node_id_reg[8*gi +: 8] == NODE_ID_DEFAULT
				|-> alias_reg[16*gi +: 16] == ALIAS_NONE) else $error("axis alias not zero");
		end
	endgenerate

	// Read data selection over all registers
	logic [31:0] axis_rd_or;
	always_comb begin
		axis_rd_or = READ_ZERO;
		for (int i = 0; i < NUM_AXES; i++) begin
			axis_rd_or = axis_rd_or | axis_rd[i];
		end
	end
	wire [31:0] rd_mux = ctrl_hit ? ctrl_word : (stat_hit ? stat_word : axis_rd_or);

	// Two-flop synchronisers on the switch pins
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			bank_meta_reg <= 4'h0;
			bank_sync_reg <= 4'h0;
			msb_meta_reg <= 1'b0;
			msb_sync_reg <= 1'b0;
		end else begin
			bank_meta_reg <= id_switch_bank_in;
			bank_sync_reg <= bank_meta_reg;
			msb_meta_reg <= protocol_or_id_msb_switch_in;
			msb_sync_reg <= msb_meta_reg;
		end
	end

	// Configuration sequence
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_SAMPLE: begin
				if (settle_done) begin
					state_next = ST_WAIT_SETUP;
				end
			end
			ST_WAIT_SETUP: begin
				if (commit_go) begin
					state_next = ST_LOCKED;
				end
			end
			ST_LOCKED: begin
				state_next = ST_LOCKED;
			end
			default: begin
				state_next = ST_SAMPLE;
			end
		endcase
	end

	// State, settle counter and one-shot switch latch
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state_reg <= ST_SAMPLE;
			settle_cnt_reg <= '0;
			bank_lat_reg <= 4'h0;
			msb_lat_reg <= 1'b0;
			vendor_reg <= 1'b0;
			locked_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			locked_reg <= (state_next == ST_LOCKED);
			if (state_reg == ST_SAMPLE) begin
				settle_cnt_reg <= settle_cnt_reg + 1'b1;
			end
			if ((state_reg == ST_SAMPLE) & settle_done) begin
				bank_lat_reg <= bank_sync_reg;
				msb_lat_reg <= msb_sync_reg;
				vendor_reg <= ~ETHERCAT_VARIANT & msb_sync_reg;
			end
		end
	end

	// Setup control bits, frozen once locked
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			ctrl_reg <= CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= avs_writedata_in[2:0];
		end
	end

	// Bus handshake: one wait cycle, then answer
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wait_reg <= 1'b1;
			rdata_reg <= READ_ZERO;
		end else begin
			wait_reg <= ~(bus_req & wait_reg);
			if (avs_read_in & wait_reg) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	// Outputs come straight from registers
	assign avs_readdata_out = rdata_reg;
	assign avs_waitrequest_out = wait_reg;
	assign node_identifier_out = node_id_reg;
	assign station_alias_out = alias_reg;
	assign vendor_can_protocol_out = vendor_reg;
	assign lss_inactive_out = lss_reg;
	assign config_locked_out = locked_reg;

	// Checks on axis 0, the protocol choice, the switch latch, the lock and the bus handshake
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	AST_SOFT_ID: assert property (commit_go && !hw_forced && setup_id_reg[7:0] != NODE_ID_NONE
		|=> node_id_reg[7:0] == $past(setup_id_reg[7:0])) else $error("software identifier not applied");
	AST_HW_ID: assert property (commit_go && hw_forced
		|=> node_id_reg[7:0] == {$past(eth_msb), $past(bank_lat_reg), 3'h1}) else $error("switch identifier not applied");
	AST_CAN_CODE: assert property (locked_reg && !ETHERCAT_VARIANT
		|-> sw_id[0] == {1'b0, bank_lat_reg, 3'h1}) else $error("CAN switch code wrong");
	AST_ETH_MSB: assert property (ETHERCAT_VARIANT && msb_lat_reg
		|-> sw_id[0] >= 8'h81 && sw_id[0] <= 8'hF9) else $error("Ethernet top bit not added");
	AST_VENDOR: assert property (state_reg != ST_SAMPLE
		|-> vendor_reg == (!ETHERCAT_VARIANT && msb_lat_reg)) else $error("protocol choice wrong");
	AST_DEFAULT: assert property (state_reg != ST_LOCKED
		|-> node_id_reg[7:0] == NODE_ID_DEFAULT) else $error("default identifier lost");
	AST_LSS: assert property (locked_reg && !ETHERCAT_VARIANT && !vendor_reg
		|-> lss_reg[0] == (node_id_reg[7:0] == NODE_ID_DEFAULT)) else $error("LSS state wrong");
	AST_ALIAS: assert property (locked_reg && ETHERCAT_VARIANT && ctrl_reg[CTRL_ALIAS_MODE_BIT]
		&& node_id_reg[7:0] != NODE_ID_DEFAULT |-> alias_reg[7:0] == node_id_reg[7:0]) else $error("alias mismatch");
	AST_ALIAS_255: assert property (node_id_reg[7:0] == NODE_ID_DEFAULT
		|-> alias_reg[15:0] == ALIAS_NONE) else $error("alias not zero");
	AST_SAMPLE_ONCE: assert property ((state_reg == ST_SAMPLE) && settle_done
		|=> state_reg == ST_WAIT_SETUP && bank_lat_reg == $past(bank_sync_reg)) else $error("sample missed");
	AST_HOLD: assert property (state_reg != ST_SAMPLE ##1 state_reg != ST_SAMPLE
		|-> $stable(bank_lat_reg) && $stable(msb_lat_reg)) else $error("latched switches changed");
	AST_LOCK_HOLD: assert property (locked_reg ##1 locked_reg
		|-> $stable(node_id_reg) && $stable(alias_reg)) else $error("identifier changed after lock");
	AST_BUS_ANSWER: assert property (bus_req && wait_reg |=> !wait_reg ##1 wait_reg) else $error("bus answer timing");

	// Sequence, latch and hold checks
	AST_ONEHOT: assert property ($onehot(state_reg))
		else $error("state code not one-hot");
	AST_SETTLE_COUNT: assert property (state_reg == ST_SAMPLE
		|-> settle_cnt_reg < SETTLE_CNT_W'(SETTLE_CYCLES)) else $error("settle count overrun");
	AST_PRE_SAMPLE: assert property (state_reg == ST_SAMPLE
		|-> !vendor_reg && !msb_lat_reg && bank_lat_reg == 4'h0) else $error("latch taken before sample");
	AST_SAMPLE_MSB: assert property ((state_reg == ST_SAMPLE) && settle_done
		|=> msb_lat_reg == $past(msb_sync_reg)) else $error("extra switch not sampled");
	AST_PRE_LOCK_ID: assert property (state_reg == ST_SAMPLE
		|-> !locked_reg && node_id_reg == {NUM_AXES{NODE_ID_DEFAULT}}) else $error("identifier set before sample");
	AST_COMMIT_LOCKS: assert property (commit_go
		|=> locked_reg && state_reg == ST_LOCKED) else $error("commit did not lock");
	AST_SETUP_FROZEN: assert property (locked_reg
		|=> $stable(setup_id_reg) && $stable(ctrl_reg)) else $error("setup changed after lock");
	AST_LOCK_VENDOR: assert property (locked_reg ##1 locked_reg
		|-> $stable(vendor_reg) && $stable(lss_reg)) else $error("protocol or LSS changed after lock");
	AST_LSS_WAIT: assert property (state_reg == ST_WAIT_SETUP && !ETHERCAT_VARIANT
		|-> lss_reg == {NUM_AXES{!vendor_reg}}) else $error("LSS state before commit wrong");

	// Variant and bus checks
	AST_ETH_NO_CAN: assert property (ETHERCAT_VARIANT
		|-> !vendor_reg && lss_reg == '0) else $error("CAN outputs active on Ethernet");
	AST_CAN_NO_ALIAS: assert property (!ETHERCAT_VARIANT
		|-> alias_reg == '0) else $error("alias set on CAN");
	AST_UNLOCKED_ALIAS: assert property (!locked_reg
		|-> alias_reg == '0) else $error("alias set before lock");
	AST_UNMAPPED_ZERO: assert property (avs_read_in && wait_reg && !ctrl_hit && !stat_hit && !(|axis_hit)
		|=> avs_readdata_out == READ_ZERO) else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!(avs_read_in && wait_reg)
		|=> $stable(avs_readdata_out)) else $error("read data changed without read");
	AST_BUS_IDLE: assert property (!bus_req && wait_reg
		|=> wait_reg) else $error("answer without request");
	AST_WAIT_ONE: assert property (!wait_reg
		|=> wait_reg) else $error("waitrequest low too long");
endmodule

// ---- dv/dip_switch_model.sv ----
// DIP switch banks seen by the decoder at power-up
`timescale 1ns/1ps
module dip_switch_model (
	input wire logic [3:0] bank_pos_in, // Positions 1..4, bit 3 is position 1
	input wire logic extra_pos_in, // Protocol or top identifier switch
	output logic [3:0] id_switch_bank_out, // To decoder bank input
	output logic protocol_or_id_msb_switch_out // To decoder extra switch input
);
	// Mechanical switches hold a level, no bounce modelled
	assign id_switch_bank_out = bank_pos_in;
	assign protocol_or_id_msb_switch_out = extra_pos_in;
endmodule

// ---- dv/node_id_strap_decoder_tb.sv ----
// Self-checking bench, CAN and Ethernet variants side by side
`timescale 1ns/1ps
module node_id_strap_decoder_tb;
	import strap_decoder_pkg::*;
	logic core_clk_in = 1'b0, sys_rst_in = 1'b1, rd = 1'b0, wr = 1'b0, msb = 1'b0, msb_s, sw_msb;
	logic hw, vld, amd;
	logic [3:0] bank = 4'h0, bank_s, sw_bank;
	logic [7:0] adr = 8'h00, sid, e;
	logic [31:0] wd = 32'h0000_0000, q, r = 32'h0000_5A08;
	logic [31:0] rdat [2], nid [2];
	logic [63:0] al [2];
	logic [3:0] lss [2];
	logic wrq [2], ven [2], lk [2];
	int fails = 0, cmp_count = 0;
	// Clock, 25 ns period
	always #12.5 core_clk_in = ~core_clk_in;
	dip_switch_model i_dip_switch_model (.bank_pos_in(bank), .extra_pos_in(msb),
		.id_switch_bank_out(sw_bank), .protocol_or_id_msb_switch_out(sw_msb));
	// Variant 0 is CAN, variant 1 is Ethernet, one shared bus
	for (genvar g = 0; g < 2; g++) begin : v
		node_id_strap_decoder #(.NUM_AXES(4), .ETHERCAT_VARIANT(g == 1)) i_node_id_strap_decoder (
			.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .id_switch_bank_in(sw_bank),
			.protocol_or_id_msb_switch_in(sw_msb), .avs_address_in(adr), .avs_read_in(rd),
			.avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
			.avs_readdata_out(rdat[g]), .avs_waitrequest_out(wrq[g]), .node_identifier_out(nid[g]),
			.station_alias_out(al[g]), .vendor_can_protocol_out(ven[g]), .lss_inactive_out(lss[g]),
			.config_locked_out(lk[g]));
	end
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Identifier expected for one axis of one variant
	function automatic [7:0] exp_id(input logic eth, input logic [2:0] ax);
		exp_id = (hw || !vld || sid == 8'h00) ? {eth & msb_s, bank_s, ax} : sid;
	endfunction
	task automatic give_verdict();
		if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		cmp_count++;
		if (got !== want) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic r_n, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_in);
		rd <= r_n;
		wr <= !r_n;
		adr <= a;
		wd <= d;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (wrq[0] !== 1'b0 && n < 20);
		q = rdat[0];
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 20) begin
			fails++;
			give_verdict();
		end
	endtask
	// Outputs of both variants after the commit
	task automatic check_all();
		for (int g = 0; g < 2; g++) begin
			chk(lk[g], 1'b1);
			for (int a = 0; a < 4; a++) begin
				e = exp_id(g[0], 3'(a + 1));
				chk(nid[g][8*a+:8], e);
				chk(al[g][16*a+:16], (g == 1 && amd && e != 8'hFF) ? e : 8'h00);
				if (g == 0) chk(lss[0][a], !msb_s && e == 8'hFF);
			end
		end
		chk(ven[0], msb_s);
		chk(ven[1], 1'b0);
		chk(lss[1], 4'h0);
	endtask
	initial begin
		for (int it = 0; it < 16; it++) begin
			r = lfsr(lfsr(r));
			bank_s = (it == 4) ? 4'h8 : (it == 5) ? 4'hF : r[3:0];
			msb_s = r[4];
			bank <= bank_s;
			msb <= msb_s;
			hw = (it < 4) ? it == 0 : r[5];
			vld = (it < 4) ? it != 1 : r[6];
			sid = (it == 3) ? 8'hFF : (it == 6) ? 8'h00 : r[15:8];
			amd = r[7] | (it == 3);
			sys_rst_in <= 1'b1;
			repeat (3) @(posedge core_clk_in);
			sys_rst_in <= 1'b0;
			repeat (48) @(posedge core_clk_in);
			for (int g = 0; g < 2; g++) begin
				chk(nid[g][31:16], 16'hFFFF);
				chk(nid[g][15:0], 16'hFFFF);
				chk(lk[g], 1'b0);
			end
			chk(lss[0], msb_s ? 4'h0 : 4'hF);
			for (int a = 0; a < 4; a++) bus(1'b0, OFS_AXIS_SETUP_BASE + 8'(4 * a), {24'h0, sid});
			bus(1'b0, OFS_SETUP_CTRL, {1'b1, 28'h0, amd, vld, hw});
			@(posedge core_clk_in);
			check_all();
			bus(1'b1, OFS_AXIS_SETUP_BASE, 32'h0);
			chk(q[15:0], {exp_id(1'b0, 3'h1), sid});
			bus(1'b1, OFS_STATUS, 32'h0);
			chk(q[15:0], {6'h00, msb_s, msb_s, bank_s, 4'h3});
			bus(1'b1, 8'hFC, 32'h0);
			chk(q[15:0], 16'h0000);
			// Later switch moves and a second commit change nothing
			bank <= ~bank_s;
			msb <= ~msb_s;
			bus(1'b0, OFS_SETUP_CTRL, {1'b1, 28'h0, ~amd, ~vld, ~hw});
			repeat (50) @(posedge core_clk_in);
			check_all();
		end
		give_verdict();
	end
endmodule
